// file: pdrc_pkg.sv
// shared types and constants for the pd phy reset and collision block
package pdrc_pkg;
  // symbol kinds exchanged with the line coder
  typedef enum logic [3:0] {
    SYM_DATA  = 4'h0,
    SYM_PRE   = 4'h1,
    SYM_SYNC1 = 4'h2,
    SYM_SYNC2 = 4'h3,
    SYM_SYNC3 = 4'h4,
    SYM_RST1  = 4'h5,
    SYM_RST2  = 4'h6,
    SYM_EOP   = 4'h7,
    SYM_BAD   = 4'h8
  } pdrc_kind_t;

  // one line symbol: kind plus data byte
  typedef struct packed {
    pdrc_kind_t kind;
    logic [7:0] data;
  } pdrc_sym_t;

  // transmit sequencer states, one-hot
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01,
    TX_PKT  = 7'h02,
    TX_EOP  = 7'h04,
    TX_WAIT = 7'h08,
    TX_GAP  = 7'h10,
    TX_SEND = 7'h20,
    TX_OFF  = 7'h40
  } pdrc_txst_t;

  localparam int         CLK_NS      = 50;     // 20 MHz clock period
  localparam int         IFG_NS      = 25000;  // inter_frame_gap_time, least
  localparam int         HOLD_NS     = 16000;  // sink_tx_holdoff_time, least
  localparam logic [9:0] IFG_CYC     = 10'((IFG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] HOLD_CYC    = 10'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] OS_LEN      = 3'h4;   // k-codes in an ordered set
  localparam logic [2:0] OS_LAST     = 3'h3;   // index of the last k-code
endpackage : pdrc_pkg

// file: pdrc_phy_ctl.sv
// pd phy control: rx drop, hard/cable reset signalling, collision avoidance
//
// Functional notes
// - crc or decode error drops message, no ack
// - line idle mid-packet drops it, no ack
// - hard reset is three RST1 then RST2
// - received hard reset resets port, tells upper layer
// - invalid hard reset sequence drops whole transmission
// - cable plug resets on partners' hard reset
// - hard reset request cuts message with EOP
// - hard reset waits idle, gap, still idle
// - after hard reset phy disabled until re-enabled
// - cable reset is RST1 SYNC1 RST1 SYNC3
// - only downstream-facing port sends cable reset
// - cable reset resets plug only, not partners
// - transmit only when line sampled idle
// - busy drop reported once line idle
// - 3A pull-up lets sink start sequence
// - 1.5A pull-up forbids sink starting sequence
// - source waits holdoff after no-go level
// - EOP may end a packet early
`timescale 1ns/10ps
module pdrc_phy_ctl
  import pdrc_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  input  wire logic      i_cc_idle,          // raw line idle detector
  input  wire logic      i_rp_seen_ok,       // raw: sink sees 3A pull-up
  input  wire logic      i_is_source,
  input  wire logic      i_is_dfp,
  input  wire logic      i_is_cable_plug,
  input  wire logic      i_rp_no_go_req,     // source asks for no-go level
  input  wire logic      i_tx_req,           // start a packet
  input  wire logic      i_tx_ams,           // packet opens a sequence
  input  wire logic      i_hr_req,           // hard reset request pulse
  input  wire logic      i_cr_req,           // cable reset request pulse
  input  wire logic      i_reenable,         // re-enable channel
  input  wire logic      i_tx_valid,
  input  wire pdrc_sym_t i_tx_sym,
  output logic           o_tx_ready,
  output pdrc_sym_t      o_line_sym,
  output logic           o_line_valid,
  input  wire logic      i_line_ready,
  input  wire logic      i_rx_valid,
  input  wire pdrc_sym_t i_rx_sym,
  input  wire logic      i_rx_crc_ok,        // residual good at EOP
  output logic           o_rx_byte_valid,
  output logic [7:0]     o_rx_byte,
  output logic           o_rx_good,          // deliver, ack allowed
  output logic           o_rx_drop,
  output logic           o_hard_reset,
  output logic           o_cable_reset,
  output logic           o_phy_reset,
  output logic           o_tx_discard,
  output logic           o_sink_tx_allowed,  // source pull-up at 3A
  output logic           o_ams_ok,
  output logic           o_tx_busy
);

  // ordered set symbol at position idx (0 is the preamble)
  function automatic pdrc_kind_t os_sym(input logic cr, input logic [2:0] idx);
    pdrc_kind_t k;
    k = SYM_PRE;
    if (idx == OS_LEN) begin
      k = cr ? SYM_SYNC3 : SYM_RST2;
    end else if (idx == 3'h2 && cr) begin
      k = SYM_SYNC1;
    end else if (idx != 3'h0) begin
      k = SYM_RST1;
    end
    return k;
  endfunction : os_sym

  // synchronisers for line-side levels
  logic       idle_m_r, idle_s_r;
  logic       rpok_m_r, rpok_s_r;
  // transmit side state
  pdrc_txst_t st_r, st_nxt;
  logic       pre_done_r;          // preamble already queued
  logic [2:0] idx_r;               // ordered set position
  logic [9:0] gap_cnt_r;           // inter-frame gap counter
  logic       rst_pend_r;          // reset signalling requested
  logic       cr_r;                // pending signalling is cable reset
  logic       busy_pend_r;         // owe a busy-drop report
  logic [9:0] hold_cnt_r;          // holdoff since no-go
  // receive side state
  logic [2:0] os_cnt_r;
  logic [11:0] os_r;               // first three header kinds
  logic       in_pkt_r;
  logic       skip_r;              // ignore rest of frame

  always_ff @(posedge i_clk) begin
    idle_m_r <= i_cc_idle;         // first stage only feeds second
    idle_s_r <= idle_m_r;          // idle threshold lives outside
    rpok_m_r <= i_rp_seen_ok;
    rpok_s_r <= rpok_m_r;
  end

  // ---------------- collision avoidance pull-up control
  wire hold_done = (hold_cnt_r == HOLD_CYC);
  wire src_ok    = ~o_sink_tx_allowed & hold_done;
  assign o_ams_ok = i_is_source ? src_ok : rpok_s_r;

  // holdoff restarts each time the pull-up returns to 3A
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sink_tx_allowed <= 1'b0;
      hold_cnt_r        <= 10'h000;
    end else begin
      o_sink_tx_allowed <= i_is_source & ~i_rp_no_go_req;
      if (o_sink_tx_allowed) begin
        hold_cnt_r <= 10'h000;
      end else if (!hold_done) begin
        hold_cnt_r <= hold_cnt_r + 10'h001;
      end
    end
  end

  // ---------------- receive classification
  wire        rx_en     = (st_r != TX_OFF);
  pdrc_kind_t rk;
  assign rk = i_rx_sym.kind;
  wire rx_act   = i_rx_valid & rx_en & ~skip_r & (rk != SYM_PRE);
  wire hdr      = rx_act & (os_cnt_r < OS_LEN);
  wire hdr_last = hdr & (os_cnt_r == OS_LAST);
  wire hr_hit   = hdr_last & (os_r == {SYM_RST1, SYM_RST1, SYM_RST1}) & (rk == SYM_RST2);
  wire cr_hit   = hdr_last & (os_r == {SYM_RST1, SYM_SYNC1, SYM_RST1}) & (rk == SYM_SYNC3);
  wire has_rst  = (rk == SYM_RST1) | (rk == SYM_RST2) | (os_r[11:8] == SYM_RST1)
                | (os_r[7:4] == SYM_RST1) | (os_r[3:0] == SYM_RST1);
  // a reset-like header that matches neither set is thrown away whole
  wire hdr_bad  = (hdr & (rk == SYM_BAD)) | (hdr_last & ~hr_hit & ~cr_hit & has_rst);
  wire pkt_bad  = in_pkt_r & rx_act & (rk == SYM_BAD);
  wire pkt_eop  = in_pkt_r & rx_act & (rk == SYM_EOP);
  wire frm_open = in_pkt_r | ((os_cnt_r != 3'h0) & ~skip_r);
  wire idle_ab  = frm_open & idle_s_r & rx_en;
  wire plug_rst = cr_hit & i_is_cable_plug;
  wire rx_reset = hr_hit | plug_rst;

  // header shift, packet tracking and result pulses
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      os_cnt_r        <= 3'h0;
      os_r            <= 12'h000;
      in_pkt_r        <= 1'b0;
      skip_r          <= 1'b0;
      o_rx_byte_valid <= 1'b0;
      o_rx_byte       <= 8'h00;
      o_rx_good       <= 1'b0;
      o_rx_drop       <= 1'b0;
      o_hard_reset    <= 1'b0;
      o_cable_reset   <= 1'b0;
    end else begin
      o_rx_byte_valid <= in_pkt_r & rx_act & (rk == SYM_DATA) & ~idle_s_r;
      if (in_pkt_r & rx_act) begin
        o_rx_byte <= i_rx_sym.data;
      end
      o_rx_good     <= pkt_eop & i_rx_crc_ok & ~idle_s_r;
      o_rx_drop     <= hdr_bad | pkt_bad | (pkt_eop & ~i_rx_crc_ok) | idle_ab;
      o_hard_reset  <= hr_hit;
      o_cable_reset <= plug_rst;
      if (idle_s_r | ~rx_en) begin
        // frame boundary: everything restarts on an idle line
        os_cnt_r <= 3'h0;
        os_r     <= 12'h000;
        in_pkt_r <= 1'b0;
        skip_r   <= 1'b0;
      end else begin
        if (hdr) begin
          os_cnt_r <= os_cnt_r + 3'h1;
          os_r     <= {os_r[7:0], rk};
        end
        if (hdr_last & ~hr_hit & ~cr_hit & ~hdr_bad) begin
          in_pkt_r <= 1'b1;
        end
        if (pkt_bad | pkt_eop) begin
          in_pkt_r <= 1'b0;
        end
        // after reset sets, errors or ends, wait for idle
        if (hdr_bad | pkt_bad | pkt_eop | hr_hit | cr_hit) begin
          skip_r <= 1'b1;
        end
      end
    end
  end

  // ---------------- transmit sequencing
  wire take    = ~o_line_valid | i_line_ready;
  wire in_pkt  = (st_r == TX_PKT);
  wire pass    = in_pkt & pre_done_r & ~rst_pend_r;
  assign o_tx_ready = pass & take;
  wire sym_v   = (in_pkt & ~pre_done_r) | (pass & i_tx_valid)
               | (st_r == TX_EOP) | (st_r == TX_SEND);
  wire adv     = sym_v & take;
  wire pkt_end = o_tx_ready & i_tx_valid & (i_tx_sym.kind == SYM_EOP);
  wire req_new = i_hr_req | (i_cr_req & i_is_dfp);
  // a request is refused when the line is busy or the sequence not allowed
  wire tx_busy_drop = i_tx_req & ~idle_s_r;
  wire tx_ams_drop  = i_tx_req & idle_s_r & i_tx_ams & ~o_ams_ok;
  assign o_tx_busy = (st_r != TX_IDLE);

  pdrc_sym_t sym_sel;
  assign sym_sel = (st_r == TX_SEND) ? pdrc_sym_t'{kind: os_sym(cr_r, idx_r), data: 8'h00}
                 : (st_r == TX_EOP) ? pdrc_sym_t'{kind: SYM_EOP, data: 8'h00}
                 : pre_done_r ? i_tx_sym : pdrc_sym_t'{kind: SYM_PRE, data: 8'h00};

  // next state of the transmit sequencer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      TX_IDLE: begin
        if (rst_pend_r) begin
          st_nxt = TX_WAIT;
        end else if (i_tx_req & ~tx_busy_drop & ~tx_ams_drop) begin
          st_nxt = TX_PKT;
        end
      end
      TX_PKT: begin
        if (rst_pend_r) begin
          st_nxt = TX_EOP;
        end else if (pkt_end) begin
          st_nxt = TX_IDLE;
        end
      end
      TX_EOP: begin
        if (adv) begin
          st_nxt = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (idle_s_r) begin
          st_nxt = TX_GAP;
        end
      end
      TX_GAP: begin
        if (!idle_s_r) begin
          st_nxt = TX_WAIT;
        end else if (gap_cnt_r == IFG_CYC - 10'h001) begin
          st_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (adv & (idx_r == OS_LEN)) begin
          st_nxt = cr_r ? TX_IDLE : TX_OFF;
        end
      end
      TX_OFF: begin
        if (i_reenable) begin
          st_nxt = TX_IDLE;
        end
      end
    endcase
    // a received reset wipes any transmit work in progress
    if (rx_reset) begin
      st_nxt = TX_IDLE;
    end
  end

  // transmit registers and the single line output stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r         <= TX_IDLE;
      pre_done_r   <= 1'b0;
      idx_r        <= 3'h0;
      gap_cnt_r    <= 10'h000;
      rst_pend_r   <= 1'b0;
      cr_r         <= 1'b0;
      busy_pend_r  <= 1'b0;
      o_line_valid <= 1'b0;
      o_line_sym   <= '{kind: SYM_DATA, data: 8'h00};
      o_phy_reset  <= 1'b0;
      o_tx_discard <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      pre_done_r  <= in_pkt & (pre_done_r | adv);
      idx_r       <= (st_r == TX_SEND) ? idx_r + {2'h0, adv} : 3'h0;
      gap_cnt_r   <= (st_r == TX_GAP) ? gap_cnt_r + 10'h001 : 10'h000;
      o_phy_reset <= (st_nxt == TX_OFF) & (st_r != TX_OFF);
      if (take) begin
        o_line_valid <= sym_v;
        o_line_sym   <= sym_sel;
      end
      // one request at a time; it clears when the last k-code is queued,
      // whether the sequencer idles or shuts off, so a re-enable never resends it
      if (req_new & (st_r != TX_OFF) & ~rst_pend_r) begin
        rst_pend_r <= 1'b1;
        cr_r       <= ~i_hr_req;
      end else if ((st_r == TX_SEND) & (st_nxt != TX_SEND) | rx_reset) begin
        rst_pend_r <= 1'b0;
      end
      // busy drop is reported only once the line is idle again
      busy_pend_r  <= (st_r == TX_IDLE) & ~rst_pend_r & tx_busy_drop
                    | busy_pend_r & ~idle_s_r;
      o_tx_discard <= busy_pend_r & idle_s_r
                    | (st_r == TX_IDLE) & ~rst_pend_r & tx_ams_drop;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_os_order: assert property ((st_r == TX_SEND) & adv |=>
    o_line_sym.kind == os_sym($past(cr_r), $past(idx_r)))
    else $error("ordered set symbol out of order");
  chk_rx_err_drop: assert property (pkt_bad |=> o_rx_drop & ~o_rx_good)
    else $error("bad symbol not dropped");
  chk_idle_drop: assert property (idle_ab |=> o_rx_drop)
    else $error("idle line did not drop frame");
  chk_hr_detect: assert property (hr_hit |=> o_hard_reset ##1 (st_r == TX_IDLE))
    else $error("hard reset not signalled");
  chk_eop_cut: assert property ((st_r == TX_PKT) & rst_pend_r |=> (st_r == TX_EOP)
    ##[0:20] (o_line_valid & o_line_sym.kind == SYM_EOP))
    else $error("message not cut with eop");
  chk_gap_wait: assert property ($rose(st_r == TX_SEND) & ~$past(rx_reset) |->
    $past(gap_cnt_r) == IFG_CYC - 10'h001)
    else $error("signalling without full gap");
  chk_off_hold: assert property ((st_r == TX_OFF) & ~i_reenable & ~rx_reset |=>
    (st_r == TX_OFF) & ~o_line_valid | $past(o_line_valid))
    else $error("channel left disabled state");
  chk_phy_rst: assert property ($rose(st_r == TX_OFF) |-> o_phy_reset)
    else $error("phy reset not reported");
  chk_busy_rep: assert property (o_tx_discard & $past(busy_pend_r) |-> $past(idle_s_r))
    else $error("busy drop reported early");
  chk_src_hold: assert property (i_is_source & (st_r == TX_IDLE) & ~rst_pend_r
    & i_tx_req & i_tx_ams & ~hold_done & ~rx_reset |=> st_r == TX_IDLE)
    else $error("source sequence before holdoff");

endmodule : pdrc_phy_ctl

// file: pdrc_partner.sv
// far-side model: line coder taking symbols, remote port sending frames
`timescale 1ns/10ps
module pdrc_partner
  import pdrc_pkg::*;
(
  input  wire logic      i_clk,
  input  wire pdrc_sym_t i_sym,
  input  wire logic      i_valid,
  input  wire logic      i_slow,      // coder stalls every other cycle
  output logic           o_ready,
  output logic           o_idle,      // line idle as seen on the wire
  output logic           o_rx_valid,
  output pdrc_sym_t      o_rx_sym,
  output logic           o_rx_crc_ok
);
  pdrc_kind_t got[$];  // kinds taken off the line, in order
  logic       ph = 1'b0;
  initial begin
    {o_ready, o_idle, o_rx_valid, o_rx_crc_ok} = 4'hC;
    o_rx_sym = '0;
  end
  // ready is judged on the edge, so it moves just after it
  always @(posedge i_clk) begin
    if (i_valid && o_ready) got.push_back(i_sym.kind);
    ph <= ~ph;
    o_ready <= #1 ~i_slow | ph;
  end
  // one frame: carrier up, preamble, symbols, release
  task automatic send(input pdrc_kind_t k[$], input logic crc, input int stop);
    o_idle = 1'b0;
    repeat (3) @(posedge i_clk);
    #1 {o_rx_valid, o_rx_sym} = {1'b1, SYM_PRE, 8'h00};
    foreach (k[i]) if (i < stop) begin
      @(posedge i_clk) #1;
      o_rx_sym = {k[i], 8'(8'hA0 + i)};
      o_rx_crc_ok = crc;
    end
    @(posedge i_clk) #1;
    o_rx_valid = 1'b0;
    o_rx_sym = ~o_rx_sym;  // released bus must not keep the old value
    o_idle = 1'b1;
  endtask : send
endmodule : pdrc_partner

// file: pdrc_phy_ctl_tb_top.sv
// self-checking bench for the pd phy reset and collision block
`timescale 1ns/10ps
module pdrc_phy_ctl_tb_top;
  import pdrc_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_rp_seen_ok = 1'b0, i_is_source = 1'b0, i_is_dfp = 1'b0;
  logic i_is_cable_plug = 1'b0, i_rp_no_go_req = 1'b0, i_tx_req = 1'b0, i_tx_ams = 1'b0;
  logic i_hr_req = 1'b0, i_cr_req = 1'b0, i_reenable = 1'b0, i_tx_valid = 1'b0, slow = 1'b0;
  logic cc_free = 1'b1;  // bench may hold the line busy
  logic i_cc_idle, cc_prt, i_line_ready, i_rx_valid, i_rx_crc_ok, o_tx_ready, o_line_valid;
  logic o_rx_byte_valid, o_rx_good, o_rx_drop, o_hard_reset, o_cable_reset, o_phy_reset;
  logic o_tx_discard, o_sink_tx_allowed, o_ams_ok, o_tx_busy;
  logic [7:0] o_rx_byte, lastb;
  pdrc_sym_t  i_tx_sym = '0, i_rx_sym, o_line_sym;
  int         error_cnt = 0, checks = 0, ev[7];
  string      nm[7] = '{"good", "drop", "hard", "cable", "phy", "discard", "bytes"};
  pdrc_kind_t sop[$] = '{SYM_SYNC1, SYM_SYNC1, SYM_SYNC1, SYM_SYNC2};
  pdrc_kind_t hrs[$] = '{SYM_RST1, SYM_RST1, SYM_RST1, SYM_RST2};
  assign i_cc_idle = cc_prt & cc_free;
  always #25 i_clk = ~i_clk;
  pdrc_phy_ctl i_dut (.i_clk, .i_rst, .i_cc_idle, .i_rp_seen_ok, .i_is_source, .i_is_dfp, .i_is_cable_plug,
    .i_rp_no_go_req, .i_tx_req, .i_tx_ams, .i_hr_req, .i_cr_req, .i_reenable, .i_tx_valid, .i_tx_sym,
    .o_tx_ready, .o_line_sym, .o_line_valid, .i_line_ready, .i_rx_valid, .i_rx_sym, .i_rx_crc_ok,
    .o_rx_byte_valid, .o_rx_byte, .o_rx_good, .o_rx_drop, .o_hard_reset, .o_cable_reset, .o_phy_reset,
    .o_tx_discard, .o_sink_tx_allowed, .o_ams_ok, .o_tx_busy);
  pdrc_partner prt (.i_clk, .i_sym(o_line_sym), .i_valid(o_line_valid), .i_slow(slow), .o_ready(i_line_ready),
    .o_idle(cc_prt), .o_rx_valid(i_rx_valid), .o_rx_sym(i_rx_sym), .o_rx_crc_ok(i_rx_crc_ok));
  // count one-cycle pulses so scenarios judge them afterwards
  always @(posedge i_clk) begin
    ev[0] += int'(o_rx_good === 1'b1);
    ev[1] += int'(o_rx_drop === 1'b1);
    ev[2] += int'(o_hard_reset === 1'b1);
    ev[3] += int'(o_cable_reset === 1'b1);
    ev[4] += int'(o_phy_reset === 1'b1);
    ev[5] += int'(o_tx_discard === 1'b1);
    ev[6] += int'(o_rx_byte_valid === 1'b1);
    if (o_rx_byte_valid === 1'b1) lastb = o_rx_byte;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // a negative entry means the count is not judged
  task automatic chk_ev(input int e[7]);
    foreach (e[i]) if (e[i] >= 0) chk(nm[i], e[i], ev[i]);
    ev = '{default: 0};
  endtask : chk_ev
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  // valid stays up between symbols; the caller drops it after the last
  task automatic put(input pdrc_kind_t k);
    i_tx_valid = 1'b1;
    i_tx_sym = {k, 8'h5A};
    for (int n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (o_tx_ready === 1'b1) break;
    end
    #1;
  endtask : put
  // bounded wait for the expected symbols, then compare in order
  task automatic chk_line(input pdrc_kind_t e[$]);
    for (int n = 0; n < 2000 && prt.got.size() < e.size(); n++) cyc(1);
    chk("line count", e.size(), prt.got.size());
    foreach (e[i]) if (i < prt.got.size()) chk("line kind", e[i], prt.got[i]);
    prt.got.delete();
  endtask : chk_line
  task automatic rx_case(input pdrc_kind_t k[$], input logic crc, input int stop, input int e[7]);
    prt.send(k, crc, stop);
    cyc(6);
    chk_ev(e);
  endtask : rx_case
  task automatic s_rx_err;
    rx_case({sop, SYM_DATA, SYM_DATA, SYM_EOP}, 1'b1, 99, '{1, 0, 0, 0, 0, 0, 2});
    chk("last byte", 8'hA5, lastb);
    rx_case({sop, SYM_DATA, SYM_EOP}, 1'b0, 99, '{0, 1, 0, 0, 0, 0, -1});
    rx_case({sop, SYM_BAD, SYM_DATA, SYM_EOP}, 1'b1, 99, '{0, 1, 0, 0, 0, 0, -1});
    rx_case({sop, SYM_DATA, SYM_DATA, SYM_EOP}, 1'b1, 5, '{0, 1, 0, 0, 0, 0, -1});
  endtask : s_rx_err
  task automatic s_rx_rst;
    i_is_cable_plug = 1'b1;
    rx_case(hrs, 1'b1, 99, '{0, 0, 1, 0, 0, 0, 0});
    rx_case('{SYM_RST1, SYM_RST1, SYM_RST2, SYM_RST1}, 1'b1, 99, '{0, 1, 0, 0, 0, 0, 0});
    rx_case('{SYM_RST1, SYM_SYNC1, SYM_RST1, SYM_SYNC3}, 1'b1, 99, '{0, 0, 0, 1, 0, 0, 0});
    i_is_cable_plug = 1'b0;
    rx_case('{SYM_RST1, SYM_SYNC1, SYM_RST1, SYM_SYNC3}, 1'b1, 99, '{0, -1, 0, 0, 0, 0, 0});
  endtask : s_rx_rst
  task automatic s_tx_pkt;  // slow coder stalls every other cycle
    slow = 1'b1;
    pulse(i_tx_req);
    put(SYM_DATA);
    put(SYM_DATA);
    put(SYM_EOP);
    i_tx_valid = 1'b0;
    chk_line('{SYM_PRE, SYM_DATA, SYM_DATA, SYM_EOP});
    cyc(2);
    chk("busy", 1'b0, o_tx_busy);
    slow = 1'b0;
  endtask : s_tx_pkt
  task automatic s_tx_busy;
    cc_free = 1'b0;
    cyc(4);
    pulse(i_tx_req);
    cyc(20);
    chk_ev('{-1, -1, -1, -1, -1, 0, -1});
    cc_free = 1'b1;
    cyc(6);
    chk_ev('{-1, -1, -1, -1, -1, 1, -1});
    chk("line count", 0, prt.got.size());
  endtask : s_tx_busy
  task automatic s_hr;  // hard reset cuts a packet in flight
    pulse(i_tx_req);
    put(SYM_DATA);
    i_tx_valid = 1'b0;
    pulse(i_hr_req);
    cyc(int'(IFG_CYC) - 20);
    chk("gap", 3, prt.got.size());
    chk_line({SYM_PRE, SYM_DATA, SYM_EOP, SYM_PRE, hrs});
    cyc(3);
    chk_ev('{-1, -1, -1, -1, 1, -1, -1});
    rx_case({sop, SYM_EOP}, 1'b1, 99, '{0, 0, 0, 0, 0, -1, 0});
    pulse(i_tx_req);
    cyc(10);
    chk("line count", 0, prt.got.size());
    pulse(i_reenable);
    cyc(3);
    rx_case({sop, SYM_EOP}, 1'b1, 99, '{1, 0, 0, 0, 0, -1, 0});
  endtask : s_hr
  task automatic s_cr;
    pulse(i_cr_req);
    cyc(int'(IFG_CYC) + 40);
    chk("line count", 0, prt.got.size());
    i_is_dfp = 1'b1;
    pulse(i_cr_req);
    chk_line('{SYM_PRE, SYM_RST1, SYM_SYNC1, SYM_RST1, SYM_SYNC3});
    cyc(3);
    chk_ev('{-1, -1, -1, -1, 0, -1, -1});
    i_is_dfp = 1'b0;
  endtask : s_cr
  task automatic s_ams;  // pull-up level decides who may open a sequence
    i_is_source = 1'b1;
    cyc(3);
    chk("sink ok", 1'b1, o_sink_tx_allowed);
    chk("ams ok", 1'b0, o_ams_ok);
    i_tx_ams = 1'b1;
    pulse(i_tx_req);
    cyc(4);
    chk_ev('{-1, -1, -1, -1, -1, 1, -1});
    i_rp_no_go_req = 1'b1;
    cyc(2);
    chk("sink ok", 1'b0, o_sink_tx_allowed);
    cyc(int'(HOLD_CYC) - 12);
    chk("ams ok", 1'b0, o_ams_ok);
    cyc(20);
    chk("ams ok", 1'b1, o_ams_ok);
    i_is_source = 1'b0;
    cyc(4);
    chk("ams ok", 1'b0, o_ams_ok);
    i_rp_seen_ok = 1'b1;
    cyc(4);
    chk("ams ok", 1'b1, o_ams_ok);
    pulse(i_tx_req);
    put(SYM_EOP);
    i_tx_valid = 1'b0;
    chk_line('{SYM_PRE, SYM_EOP});
  endtask : s_ams
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // the whole run needs about 2200 cycles
  initial begin
    #400us;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_rst = 1'b0;
    cyc(3);
    ev = '{default: 0};
    s_rx_err();
    s_rx_rst();
    s_tx_pkt();
    s_tx_busy();
    s_hr();
    s_cr();
    s_ams();
    finish_test();
  end
endmodule : pdrc_phy_ctl_tb_top
